// ---- dv/bsd_ctl_model.sv ----
// Board test controller model driving the four-wire test port
`timescale 1ns/100ps
module bsd_ctl_model (
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  input  wire logic tdo,
  input  wire logic tdo_oe
);
  localparam int HALF_NS = 24;
  logic oe_any;

  // Test clock parked low between frames
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
    oe_any = 1'b0;
  end

  // One period: inputs move while low, output taken at the rise
  task automatic step(input logic m, input logic d, output logic q, output logic o);
    tms = m;
    tdi = d;
    #HALF_NS;
    tck = 1'b1;
    q = tdo;
    o = tdo_oe;
    #HALF_NS;
    tck = 1'b0;
  endtask

  // Five highs reach logic reset from any state, then idle
  task automatic reset_tap();
    logic q;
    logic o;
    repeat (5) step(1'b1, 1'b0, q, o);
    step(1'b0, 1'b0, q, o);
  endtask

  // Idle to shift, n bits, back to idle through update
  task automatic scan(input logic ir, input int n, input logic [31:0] din,
                      output logic [31:0] dout);
    logic q;
    logic o;
    dout = '0;
    oe_any = 1'b0;
    step(1'b1, 1'b0, q, o);
    if (ir) step(1'b1, 1'b0, q, o);
    step(1'b0, 1'b0, q, o);
    step(1'b0, 1'b0, q, o);
    // Least significant bit leaves and enters first
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], q, o);
      dout[i] = q;
      oe_any = oe_any | o;
    end
    step(1'b1, 1'b0, q, o);
    step(1'b0, 1'b0, q, o);
  endtask
endmodule

// ---- dv/bsd_scan_top_test.sv ----
// Self-checking bench for the boundary-scan test logic
`timescale 1ns/100ps
module bsd_scan_top_test;
  import bsd_pkg::*;
  localparam int          REV  = 17;
  localparam logic [15:0] PART = 16'hC3A5;  // Arbitrary value
  localparam logic [10:0] MFR  = 11'h0D2;   // Arbitrary value
  localparam logic [31:0] ID   = {4'(REV % 16), PART, MFR, 1'b1};

  logic           mclk;
  logic           mclk_run;
  logic           rst;
  logic           tck;
  logic           tms;
  logic           tdi;
  logic           tdo;
  logic           tdo_oe;
  logic           tap_enable_fuse;
  logic           tap_disable_bit;
  logic [1:0]     clk_option_fuse;
  logic           ext_reset_n;
  logic           core_reset;
  bsd_pin_drive_t core_drive;
  logic [7:0]     pin_in;
  logic [7:0]     pin_out;
  logic [7:0]     pin_oe;
  logic [31:0]    d;
  logic [31:0]    exp_cap;
  logic [7:0]     exp_out;
  logic [7:0]     exp_oe;
  int             fails;
  int             cmp_count;
  int             cnt;
  localparam logic [23:0] PRE = 24'h5A6C93;

  // Core clock; the gate lets a scan run with the core stopped
  initial begin
    mclk = 1'b0;
    forever #20 mclk = mclk_run ? ~mclk : mclk;
  end

  bsd_scan_top #(.SILICON_REV(REV), .PART_CODE(PART), .MFR_CODE(MFR)) dut (
    .mclk(mclk), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe),
    .tap_enable_fuse(tap_enable_fuse), .tap_disable_bit(tap_disable_bit),
    .clk_option_fuse(clk_option_fuse), .ext_reset_n(ext_reset_n), .core_reset(core_reset),
    .core_drive(core_drive), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));

  bsd_ctl_model ctl (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe));

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Bounded wait for the core reset to drop, counting core cycles
  task automatic wait_release(output int n);
    n = 0;
    while (core_reset !== 1'b0 && n < 5000) begin
      @(posedge mclk);
      #1;
      n++;
    end
    if (n >= 5000) begin
      fails++;
      wrap_up();
    end
  endtask

  // Hang guard on top of the bounded waits
  initial begin
    #3000000;
    fails++;
    wrap_up();
  end

  initial begin
    fails = 0;
    cmp_count = 0;
    mclk_run = 1'b1;
    rst = 1'b1;
    tap_enable_fuse = 1'b1;
    tap_disable_bit = 1'b0;
    clk_option_fuse = 2'h0;
    ext_reset_n = 1'b1;
    core_drive = '{oe: 8'hFF, dout: 8'h3C};
    pin_in = 8'h96;
    // Test clock must also see edges while reset is held
    ctl.reset_tap();
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    wait_release(cnt);
    // Scans start from idle, so leave logic reset first
    ctl.reset_tap();
    // Power-up word read with the core clock stopped
    mclk_run = 1'b0;
    ctl.scan(1'b0, 32, 32'h0, d);
    check("idcode", ID, d);
    check("tdo_oe", 32'h1, 32'(ctl.oe_any));
    mclk_run = 1'b1;
    ctl.scan(1'b1, 4, 32'(BSD_OP_BYPASS), d);
    check("ir_capture", 32'(BSD_IR_CAPTURE), d);
    // Bypass and an unassigned opcode: one stage, zero first
    for (int k = 0; k < 2; k++) begin
      ctl.scan(1'b1, 4, 32'(k == 0 ? BSD_OP_BYPASS : 4'h5), d);
      ctl.scan(1'b0, 8, 32'hA5, d);
      check("bypass", 32'h4A, d);
    end
    ctl.reset_tap();
    ctl.scan(1'b0, 32, 32'h0, d);
    check("idcode_after_tlr", ID, d);
    // Snapshot of pins while the core keeps driving; preload safe values
    for (int i = 0; i < 8; i++) begin
      exp_cap[3*i]   = pin_in[i];
      exp_cap[3*i+1] = core_drive.dout[i];
      exp_cap[3*i+2] = core_drive.oe[i];
      exp_out[i]     = PRE[3*i+1];
      exp_oe[i]      = PRE[3*i+2];
    end
    exp_cap[31:24] = 8'h00;
    ctl.scan(1'b1, 4, 32'(BSD_OP_SAMPLE), d);
    ctl.scan(1'b0, 24, 32'(PRE), d);
    check("sample_capture", exp_cap, d);
    check("sample_pin_out", 32'h3C, 32'(pin_out));
    check("sample_pin_oe", 32'hFF, 32'(pin_oe));
    // Board test with the core held in reset
    @(posedge mclk);
    ext_reset_n <= 1'b0;
    ctl.scan(1'b1, 4, 32'(BSD_OP_EXTEST), d);
    check("extest_pin_out", 32'(exp_out), 32'(pin_out));
    check("extest_pin_oe", 32'(exp_oe), 32'(pin_oe));
    ctl.reset_tap();
    check("reset_float", 32'h0, 32'(pin_oe));
    @(posedge mclk);
    ext_reset_n <= 1'b1;
    wait_release(cnt);
    // Reset bit: acts while shifting, then a fuse-selected hold-off
    for (int f = 0; f < 4; f++) begin
      @(posedge mclk);
      clk_option_fuse <= 2'(f);
      ctl.scan(1'b1, 4, 32'(BSD_OP_CORERST), d);
      ctl.scan(1'b0, 1, 32'h1, d);
      check("rstbit_core_reset", 32'h1, 32'(core_reset));
      check("rstbit_pin_oe", 32'h0, 32'(pin_oe));
      ctl.scan(1'b0, 1, 32'h0, d);
      check("timeout_pin_oe", 32'h0, 32'(pin_oe));
      wait_release(cnt);
      d = 32'((f == 0 ? BSD_RTO0_NS : f == 1 ? BSD_RTO1_NS :
               f == 2 ? BSD_RTO2_NS : BSD_RTO3_NS) / BSD_MCLK_NS);
      check("timeout_window", 32'h1, 32'(cnt >= d - 8 && cnt <= d + 3));
    end
    // External reset pin acts without waiting for a clock
    @(posedge mclk);
    ext_reset_n <= 1'b0;
    #1;
    check("ext_core_reset", 32'h1, 32'(core_reset));
    check("ext_pin_oe", 32'h0, 32'(pin_oe));
    @(posedge mclk);
    ext_reset_n <= 1'b1;
    wait_release(cnt);
    // Disable bit shuts the port off
    @(posedge mclk);
    tap_disable_bit <= 1'b1;
    ctl.scan(1'b0, 32, 32'h0, d);
    check("disabled_tdo_oe", 32'h0, 32'(ctl.oe_any));
    @(posedge mclk);
    tap_disable_bit <= 1'b0;
    ctl.reset_tap();
    ctl.scan(1'b0, 32, 32'h0, d);
    check("reenabled_idcode", ID, d);
    wrap_up();
  end
endmodule

// ---- rtl/bsd_scan_top.sv ----
// Boundary-scan test access port with its data registers and pin muxing
`timescale 1ns/100ps
module bsd_scan_top
  import bsd_pkg::*;
#(
  parameter int          SILICON_REV = 0,
  parameter logic [15:0] PART_CODE   = 16'h5A3C,  // Arbitrary value
  parameter logic [10:0] MFR_CODE    = 11'h2B6    // Arbitrary value
) (
  input  wire logic                mclk,
  input  wire logic                rst,
  input  wire logic                tck,
  input  wire logic                tms,
  input  wire logic                tdi,
  output logic                     tdo,
  output logic                     tdo_oe,
  input  wire logic                tap_enable_fuse,
  input  wire logic                tap_disable_bit,
  input  wire logic [1:0]          clk_option_fuse,
  input  wire logic                ext_reset_n,
  output logic                     core_reset,
  input  wire bsd_pin_drive_t      core_drive,
  input  wire logic [BSD_NPIN-1:0] pin_in,
  output logic [BSD_NPIN-1:0]      pin_out,
  output logic [BSD_NPIN-1:0]      pin_oe
);

  // Least time rounded up to mclk cycles, never under one
  function automatic logic [BSD_RTO_CNT_W-1:0] ns_to_cycles(input int ns);
    int c;
    c = (ns + BSD_MCLK_NS - 1) / BSD_MCLK_NS;
    if (c < 1) begin
      c = 1;
    end
    return c[BSD_RTO_CNT_W-1:0];
  endfunction

  // Identification word assembly
  function automatic logic [BSD_ID_W-1:0] id_word();
    logic [BSD_ID_W-1:0] w;
    logic [31:0]         rev;
    w   = '0;
    rev = SILICON_REV;
    w[BSD_VER_LSB +: BSD_VER_W]   = rev[BSD_VER_W-1:0];
    w[BSD_PART_LSB +: BSD_PART_W] = PART_CODE;
    w[BSD_MFR_LSB +: BSD_MFR_W]   = MFR_CODE;
    w[0]                          = BSD_ID_MARKER;
    return w;
  endfunction

  // Controller next state from the mode select
  function automatic bsd_tap_state_t tap_next(input bsd_tap_state_t s, input logic m);
    bsd_tap_state_t n;
    n = s;
    unique case (s)
      BSD_TLR:      n = m ? BSD_TLR      : BSD_RTI;
      BSD_RTI:      n = m ? BSD_SEL_DR   : BSD_RTI;
      BSD_SEL_DR:   n = m ? BSD_SEL_IR   : BSD_CAP_DR;
      BSD_CAP_DR:   n = m ? BSD_EXIT1_DR : BSD_SHIFT_DR;
      BSD_SHIFT_DR: n = m ? BSD_EXIT1_DR : BSD_SHIFT_DR;
      BSD_EXIT1_DR: n = m ? BSD_UPD_DR   : BSD_PAUSE_DR;
      BSD_PAUSE_DR: n = m ? BSD_EXIT2_DR : BSD_PAUSE_DR;
      BSD_EXIT2_DR: n = m ? BSD_UPD_DR   : BSD_SHIFT_DR;
      BSD_UPD_DR:   n = m ? BSD_SEL_DR   : BSD_RTI;
      BSD_SEL_IR:   n = m ? BSD_TLR      : BSD_CAP_IR;
      BSD_CAP_IR:   n = m ? BSD_EXIT1_IR : BSD_SHIFT_IR;
      BSD_SHIFT_IR: n = m ? BSD_EXIT1_IR : BSD_SHIFT_IR;
      BSD_EXIT1_IR: n = m ? BSD_UPD_IR   : BSD_PAUSE_IR;
      BSD_PAUSE_IR: n = m ? BSD_EXIT2_IR : BSD_PAUSE_IR;
      BSD_EXIT2_IR: n = m ? BSD_UPD_IR   : BSD_SHIFT_IR;
      BSD_UPD_IR:   n = m ? BSD_SEL_DR   : BSD_RTI;
    endcase
    return n;
  endfunction

  localparam logic [BSD_ID_W-1:0] ID_VALUE = id_word();

  bsd_tap_state_t             tap_state_reg;
  bsd_tap_state_t             tap_state_next;
  logic [BSD_IR_W-1:0]        ir_shift_reg;
  logic [BSD_IR_W-1:0]        ir_reg;
  logic                       bypass_reg;
  logic [BSD_ID_W-1:0]        id_shift_reg;
  logic                       test_reset_bit_reg;
  logic [BSD_CHAIN_LEN-1:0]   chain_reg;
  bsd_pin_drive_t             upd_drive_reg;
  logic                       tdo_reg;
  logic                       tdo_oe_reg;
  logic                       disable_sync;
  logic [BSD_CHAIN_LEN-1:0]   cap_raw;
  logic [BSD_CHAIN_LEN-1:0]   cap_sync;
  logic [1:0]                 rst_src_sync;
  logic [BSD_RTO_CNT_W-1:0]   rto_cnt_reg;
  logic [BSD_RTO_CNT_W-1:0]   rto_load;

  // Port enable and instruction decode
  wire tap_en    = tap_enable_fuse & ~disable_sync;
  wire sel_ext   = (ir_reg == BSD_OP_EXTEST);
  wire sel_id    = (ir_reg == BSD_OP_IDCODE);
  wire sel_samp  = (ir_reg == BSD_OP_SAMPLE);
  wire sel_rst   = (ir_reg == BSD_OP_CORERST);
  wire sel_chain = sel_ext | sel_samp;
  // Private and unassigned codes fall back to the bypass stage
  wire sel_byp   = ~(sel_chain | sel_id | sel_rst);
  wire in_cap_dr = (tap_state_reg == BSD_CAP_DR);
  wire in_sh_dr  = (tap_state_reg == BSD_SHIFT_DR);
  wire in_sh_ir  = (tap_state_reg == BSD_SHIFT_IR);
  wire in_upd_dr = (tap_state_reg == BSD_UPD_DR);
  wire extest_on = sel_ext & tap_en;

  // Disable bit lives in the core clock domain
  bsd_sync2 #(.WIDTH(1), .RESET_VAL(1'b0)) u_dis_sync (
    .clk (tck),
    .rst (rst),
    .d   (tap_disable_bit),
    .q   (disable_sync)
  );

  // Capture vector: pins plus core drive, brought onto the test clock
  genvar gi;
  generate
    for (gi = 0; gi < BSD_NPIN; gi++) begin : g_cap
      assign cap_raw[gi*BSD_CELLS+BSD_CELL_IN]   = pin_in[gi];
      assign cap_raw[gi*BSD_CELLS+BSD_CELL_DOUT] = core_drive.dout[gi];
      assign cap_raw[gi*BSD_CELLS+BSD_CELL_OE]   = core_drive.oe[gi];
    end
  endgenerate

  bsd_sync2 #(.WIDTH(BSD_CHAIN_LEN), .RESET_VAL(1'b0)) u_cap_sync (
    .clk (tck),
    .rst (rst),
    .d   (cap_raw),
    .q   (cap_sync)
  );

  // Controller; a disabled port parks in logic reset
  assign tap_state_next = tap_en ? tap_next(tap_state_reg, tms) : BSD_TLR;

  // All test-side state runs on the test clock only
  always_ff @(posedge tck or posedge rst) begin
    if (rst) begin
      tap_state_reg <= BSD_TLR;
    end else begin
      tap_state_reg <= tap_state_next;
    end
  end

  // Instruction register, LSB first
  always_ff @(posedge tck or posedge rst) begin
    if (rst) begin
      ir_shift_reg <= BSD_IR_CAPTURE;
      ir_reg       <= BSD_OP_IDCODE;
    end else if (tap_state_reg == BSD_TLR) begin
      ir_reg       <= BSD_OP_IDCODE;
    end else if (tap_state_reg == BSD_CAP_IR) begin
      ir_shift_reg <= BSD_IR_CAPTURE;
    end else if (in_sh_ir) begin
      ir_shift_reg <= {tdi, ir_shift_reg[BSD_IR_W-1:1]};
    end else if (tap_state_reg == BSD_UPD_IR) begin
      ir_reg       <= ir_shift_reg;
    end
  end

  // Bypass and identification registers
  always_ff @(posedge tck or posedge rst) begin
    if (rst) begin
      bypass_reg   <= 1'b0;
      id_shift_reg <= '0;
    end else begin
      if (in_cap_dr && sel_byp) begin
        bypass_reg <= 1'b0;
      end else if (in_sh_dr && sel_byp) begin
        bypass_reg <= tdi;
      end
      if (in_cap_dr && sel_id) begin
        id_shift_reg <= ID_VALUE;
      end else if (in_sh_dr && sel_id) begin
        id_shift_reg <= {tdi, id_shift_reg[BSD_ID_W-1:1]};
      end
    end
  end

  // Reset bit has no update latch: it acts as soon as it shifts in
  always_ff @(posedge tck or posedge rst) begin
    if (rst) begin
      test_reset_bit_reg <= 1'b0;
    end else if (!tap_en) begin
      test_reset_bit_reg <= 1'b0;
    end else if (in_sh_dr && sel_rst) begin
      test_reset_bit_reg <= tdi;
    end
  end

  // Boundary chain and its update latches
  always_ff @(posedge tck or posedge rst) begin
    if (rst) begin
      chain_reg     <= '0;
      upd_drive_reg <= '0;
    end else if (sel_chain) begin
      if (in_cap_dr) begin
        chain_reg <= cap_sync;
      end else if (in_sh_dr) begin
        chain_reg <= {tdi, chain_reg[BSD_CHAIN_LEN-1:1]};
      end else if (in_upd_dr) begin
        for (int i = 0; i < BSD_NPIN; i++) begin
          upd_drive_reg.dout[i] <= chain_reg[i*BSD_CELLS+BSD_CELL_DOUT];
          upd_drive_reg.oe[i]   <= chain_reg[i*BSD_CELLS+BSD_CELL_OE];
        end
      end
    end
  end

  // Serial output selection
  wire dr_out = sel_chain ? chain_reg[0] :
                sel_id    ? id_shift_reg[0] :
                sel_rst   ? test_reset_bit_reg : bypass_reg;
  wire tdo_next = in_sh_ir ? ir_shift_reg[0] : dr_out;

  // Output changes on the falling edge so the far end samples it stable
  always_ff @(negedge tck or posedge rst) begin
    if (rst) begin
      tdo_reg    <= 1'b0;
      tdo_oe_reg <= 1'b0;
    end else begin
      tdo_reg    <= tdo_next;
      tdo_oe_reg <= tap_en & (in_sh_ir | in_sh_dr);
    end
  end

  assign tdo    = tdo_reg;
  assign tdo_oe = tdo_oe_reg;

  // Reset request: pin or reset bit, combinational so pins float at once
  wire reset_now = ~ext_reset_n | test_reset_bit_reg;

  // Pin mux; external test owns the pins even while the core is in reset
  assign pin_out = extest_on ? upd_drive_reg.dout : core_drive.dout;
  // Float for the whole reset, time-out included, not only while a source stands
  assign pin_oe  = extest_on  ? upd_drive_reg.oe :
                   core_reset ? '0 : core_drive.oe;

  // Both reset sources are asynchronous to the core clock
  bsd_sync2 #(.WIDTH(2), .RESET_VAL(1'b1)) u_rst_sync (
    .clk (mclk),
    .rst (rst),
    .d   ({~ext_reset_n, test_reset_bit_reg}),
    .q   (rst_src_sync)
  );

  wire rst_req_s = |rst_src_sync;

  // Time-out length chosen by clock-option fuses
  assign rto_load = (clk_option_fuse == 2'h0) ? ns_to_cycles(BSD_RTO0_NS) :
                    (clk_option_fuse == 2'h1) ? ns_to_cycles(BSD_RTO1_NS) :
                    (clk_option_fuse == 2'h2) ? ns_to_cycles(BSD_RTO2_NS) :
                                                ns_to_cycles(BSD_RTO3_NS);

  // Counter reloads while requested, runs down after release
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rto_cnt_reg <= '0;
    end else if (rst_req_s) begin
      rto_cnt_reg <= rto_load;
    end else if (rto_cnt_reg != '0) begin
      rto_cnt_reg <= rto_cnt_reg - 1'b1;
    end
  end

  // Immediate assertion path plus the held time-out
  assign core_reset = rst | reset_now | rst_req_s | (rto_cnt_reg != '0);

  // Checks on the test clock
  property p_idcode_default;
    @(posedge tck) disable iff (rst)
      tap_state_reg == BSD_TLR |=> ir_reg == BSD_OP_IDCODE;
  endproperty
  a_idcode_default: assert property (p_idcode_default)
    else $error("instruction not IDCODE after logic reset");

  property p_bypass_zero;
    @(posedge tck) disable iff (rst)
      in_cap_dr && sel_byp |=> bypass_reg == 1'b0;
  endproperty
  a_bypass_zero: assert property (p_bypass_zero)
    else $error("bypass stage not zero after capture");

  property p_id_capture;
    @(posedge tck) disable iff (rst)
      in_cap_dr && sel_id |=> id_shift_reg == ID_VALUE && id_shift_reg[0];
  endproperty
  a_id_capture: assert property (p_id_capture)
    else $error("identification word not captured");

  property p_five_tms;
    @(posedge tck) disable iff (rst)
      tms [*5] |=> tap_state_reg == BSD_TLR;
  endproperty
  a_five_tms: assert property (p_five_tms)
    else $error("five TMS highs did not reach logic reset");

  property p_reset_shift;
    @(posedge tck) disable iff (rst)
      in_sh_dr && sel_rst && tap_en ##0 tdi |=> core_reset;
  endproperty
  a_reset_shift: assert property (p_reset_shift)
    else $error("reset bit did not reset core at once");

  property p_disabled_park;
    @(posedge tck) disable iff (rst)
      !tap_en |=> tap_state_reg == BSD_TLR && !test_reset_bit_reg;
  endproperty
  a_disabled_park: assert property (p_disabled_park)
    else $error("disabled port left logic reset");

  property p_extest_drive;
    @(posedge tck) disable iff (rst)
      $rose(extest_on) |-> pin_oe == upd_drive_reg.oe && pin_out == upd_drive_reg.dout;
  endproperty
  a_extest_drive: assert property (p_extest_drive)
    else $error("external test did not drive latches");

  property p_sample_quiet;
    @(posedge tck) disable iff (rst)
      sel_samp && in_upd_dr |=> pin_out == core_drive.dout;
  endproperty
  a_sample_quiet: assert property (p_sample_quiet)
    else $error("sample update disturbed pin outputs");

  // Checks on the core clock
  property p_float_in_reset;
    @(posedge mclk) disable iff (rst)
      !extest_on && rst_req_s |-> pin_oe == '0 && core_reset;
  endproperty
  a_float_in_reset: assert property (p_float_in_reset)
    else $error("pins driven during reset");

  property p_timeout_hold;
    @(posedge mclk) disable iff (rst)
      $fell(rst_req_s) |-> core_reset && rto_cnt_reg == rto_load;
  endproperty
  a_timeout_hold: assert property (p_timeout_hold)
    else $error("reset released without time-out");

  // Main scenarios
  c_ir_update: cover property (@(posedge tck) disable iff (rst)
    tap_state_reg == BSD_UPD_IR);
  c_extest: cover property (@(posedge tck) disable iff (rst) $rose(extest_on));
  c_test_reset: cover property (@(posedge mclk) disable iff (rst) $fell(rst_req_s));
  c_id_scan: cover property (@(posedge tck) disable iff (rst) in_sh_dr && sel_id);

endmodule

// ---- rtl/bsd_sync2.sv ----
// Two-flop level synchroniser, one bit per lane
`timescale 1ns/100ps
module bsd_sync2 #(
  parameter int         WIDTH     = 1,
  parameter logic [0:0] RESET_VAL = 1'b0
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_reg;

  // First stage feeds only the second stage
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_reg <= {WIDTH{RESET_VAL}};
      q        <= {WIDTH{RESET_VAL}};
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end

endmodule

// ---- shared/bsd_pkg.sv ----
// Shared constants and types for the boundary-scan test logic
package bsd_pkg;

  // Boundary pins covered by the scan chain, three cells each
  localparam int BSD_NPIN       = 8;
  localparam int BSD_CELLS      = 3;
  localparam int BSD_CHAIN_LEN  = BSD_NPIN * BSD_CELLS;
  localparam int BSD_CELL_IN    = 0;
  localparam int BSD_CELL_DOUT  = 1;
  localparam int BSD_CELL_OE    = 2;

  // Instruction register
  localparam int       BSD_IR_W        = 4;
  localparam logic [3:0] BSD_IR_CAPTURE = 4'h1;
  localparam logic [3:0] BSD_OP_EXTEST  = 4'h0;
  localparam logic [3:0] BSD_OP_IDCODE  = 4'h1;
  localparam logic [3:0] BSD_OP_SAMPLE  = 4'h2;
  localparam logic [3:0] BSD_OP_CORERST = 4'hC;
  localparam logic [3:0] BSD_OP_BYPASS  = 4'hF;

  // Identification word layout
  localparam int BSD_ID_W       = 32;
  localparam int BSD_VER_LSB    = 28;
  localparam int BSD_VER_W      = 4;
  localparam int BSD_PART_LSB   = 12;
  localparam int BSD_PART_W     = 16;
  localparam int BSD_MFR_LSB    = 1;
  localparam int BSD_MFR_W      = 11;
  localparam logic BSD_ID_MARKER = 1'b1;

  // Core clock and reset time-out options, selected by clock-option fuses
  localparam int BSD_MCLK_NS    = 40;
  localparam int BSD_RTO0_NS    = 4000;
  localparam int BSD_RTO1_NS    = 16000;
  localparam int BSD_RTO2_NS    = 65000;
  localparam int BSD_RTO3_NS    = 100000;
  localparam int BSD_RTO_CNT_W  = 12;

  // Test access port controller states
  typedef enum logic [3:0] {
    BSD_TLR      = 4'h0,
    BSD_RTI      = 4'h1,
    BSD_SEL_DR   = 4'h2,
    BSD_CAP_DR   = 4'h3,
    BSD_SHIFT_DR = 4'h4,
    BSD_EXIT1_DR = 4'h5,
    BSD_PAUSE_DR = 4'h6,
    BSD_EXIT2_DR = 4'h7,
    BSD_UPD_DR   = 4'h8,
    BSD_SEL_IR   = 4'h9,
    BSD_CAP_IR   = 4'hA,
    BSD_SHIFT_IR = 4'hB,
    BSD_EXIT1_IR = 4'hC,
    BSD_PAUSE_IR = 4'hD,
    BSD_EXIT2_IR = 4'hE,
    BSD_UPD_IR   = 4'hF
  } bsd_tap_state_t;

  // Drive pair for the port pins
  typedef struct packed {
    logic [BSD_NPIN-1:0] oe;
    logic [BSD_NPIN-1:0] dout;
  } bsd_pin_drive_t;

endpackage
